// >>> logic/game_port_pkg.sv
// Constants shared by the dual game port block
package game_port_pkg;

	localparam int CLOCK_PERIOD_NS = 10;

	// Configuration indices
	localparam logic [7:0] CFG_BASE_HIGH_INDEX = 8'h60;
	localparam logic [7:0] CFG_BASE_LOW_INDEX = 8'h61;
	localparam logic [7:0] CFG_ACTIVATE_INDEX = 8'h30;
	localparam logic [7:0] CFG_POWER_CONTROL_INDEX = 8'h22;

	// Configuration field positions and reset values
	localparam int ACTIVATE_BIT = 0;
	localparam int POWER_GAME_BIT = 2;
	localparam logic [7:0] BASE_HIGH_RESET = 8'h00;
	localparam logic [7:0] BASE_LOW_RESET = 8'h00;
	localparam logic ACTIVATE_RESET = 1'b0;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;

	// Port register
	localparam logic [15:0] PORT_OFFSET = 16'h0000;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam int STICK1_X_POS = 0;
	localparam int STICK1_Y_POS = 1;
	localparam int STICK2_X_POS = 2;
	localparam int STICK2_Y_POS = 3;
	localparam int STICK1_BUTTON1_POS = 4;
	localparam int STICK1_BUTTON2_POS = 5;
	localparam int STICK2_BUTTON1_POS = 6;
	localparam int STICK2_BUTTON2_POS = 7;

	// Least time the RC node is held discharged after a restart
	localparam int DISCHARGE_TIME_NS = 1000;
	localparam int DISCHARGE_CYCLES = (DISCHARGE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	typedef enum logic [1:0] {
		AXIS_IDLE = 2'b00,
		AXIS_DISCHARGE = 2'b01,
		AXIS_CHARGE = 2'b10
	} axis_state_e;

endpackage

// >>> logic/axis_timer_channel.sv
// One axis timer channel: RC discharge control and timed output bit
`timescale 1ns/1ps
module axis_timer_channel import game_port_pkg::*; #(
	parameter int DISCHARGE_COUNT = DISCHARGE_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic restart,
	input wire logic threshold_reached,
	output logic timer_out,
	output logic discharge
);

	localparam int CW = $clog2(DISCHARGE_COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(DISCHARGE_COUNT - 1);

	axis_state_e state;
	axis_state_e next_state;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic next_timer_out;
	logic next_discharge;

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			AXIS_IDLE: begin
				next_count = '0;
			end
			AXIS_DISCHARGE: begin
				if (count == LAST) begin
					next_state = AXIS_CHARGE;
					next_count = '0;
				end else begin
					next_count = count + 1'b1;
				end
			end
			AXIS_CHARGE: begin
				if (threshold_reached) begin
					next_state = AXIS_IDLE;
				end
			end
			default: begin
				next_state = AXIS_IDLE;
				next_count = '0;
			end
		endcase
		if (restart) begin
			next_state = AXIS_DISCHARGE;
			next_count = '0;
		end
		next_timer_out = (next_state != AXIS_IDLE);
		next_discharge = (next_state != AXIS_CHARGE);
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= AXIS_IDLE;
			count <= '0;
			timer_out <= 1'b0;
			discharge <= 1'b1;
		end else begin
			state <= next_state;
			count <= next_count;
			timer_out <= next_timer_out;
			discharge <= next_discharge;
		end
	end

endmodule

// >>> logic/dual_joystick_game_port.sv
// Dual joystick game port: decode, configuration, axis timers and port register
// Operation
// - Two ports, each two axis timers, two buttons
// - Port write discharges and restarts all axis timers
// - Restart happens on write strobe trailing edge
// - Threshold crossing clears bit, discharges RC input
// - Fixed bit layout of buttons and axes
// - Eight-bit read-only register, offset zero, resets 00h
// - I/O read/write at base are port cycles
// - Base address from indices 0x60 high, 0x61 low
// - Activate cleared disables base address decoding
// - Power-control bit 2 mirrors the activate bit
`timescale 1ns/1ps
module dual_joystick_game_port import game_port_pkg::*; #(
	parameter int DISCHARGE_COUNT = DISCHARGE_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [15:0] io_addr,
	input wire logic io_read,
	input wire logic io_write,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_write,
	output logic [7:0] cfg_rdata,
	input wire logic stick1_axis_x_rc_input,
	input wire logic stick1_axis_y_rc_input,
	input wire logic stick2_axis_x_rc_input,
	input wire logic stick2_axis_y_rc_input,
	input wire logic stick1_button1,
	input wire logic stick1_button2,
	input wire logic stick2_button1,
	input wire logic stick2_button2,
	output logic stick1_axis_x_discharge,
	output logic stick1_axis_y_discharge,
	output logic stick2_axis_x_discharge,
	output logic stick2_axis_y_discharge,
	output logic [7:0] io_rdata,
	output logic port_read_cycle,
	output logic port_write_cycle
);

	// Pin synchronisers: axis comparators and buttons
	logic [3:0] rc_meta;
	logic [3:0] rc_sync;
	logic [3:0] button_meta;
	logic [3:0] button_sync;
	logic [3:0] rc_pins;
	logic [3:0] button_pins;

	// Configuration state
	logic [7:0] base_high;
	logic [7:0] base_low;
	logic activate;
	logic [7:0] power_control_config;
	logic [7:0] next_base_high;
	logic [7:0] next_base_low;
	logic next_activate;
	logic [7:0] next_power_control_config;
	logic [7:0] next_cfg_rdata;

	// Host cycle state
	logic write_prev;
	logic write_hit;
	logic read_prev;
	logic next_write_hit;
	logic next_port_write_cycle;
	logic next_port_read_cycle;
	logic [7:0] next_io_rdata;
	logic [7:0] joystick_port_state;
	logic [7:0] next_joystick_port_state;
	logic [15:0] port_base;
	logic address_hit;

	// Channel outputs
	logic [3:0] axis_bits;
	logic [3:0] axis_discharge;

	assign rc_pins = {stick2_axis_y_rc_input, stick2_axis_x_rc_input,
		stick1_axis_y_rc_input, stick1_axis_x_rc_input};
	assign button_pins = {stick2_button2, stick2_button1, stick1_button2, stick1_button1};

	always_ff @(posedge clock) begin
		if (!resetn) begin
			rc_meta <= '0;
			rc_sync <= '0;
			button_meta <= '0;
			button_sync <= '0;
		end else begin
			rc_meta <= rc_pins;
			rc_sync <= rc_meta;
			button_meta <= button_pins;
			button_sync <= button_meta;
		end
	end

	// Configuration registers
	always_comb begin
		next_base_high = base_high;
		next_base_low = base_low;
		next_activate = activate;
		next_power_control_config = power_control_config;
		if (cfg_write) begin
			case (cfg_index)
				CFG_BASE_HIGH_INDEX: begin
					next_base_high = cfg_wdata;
				end
				CFG_BASE_LOW_INDEX: begin
					next_base_low = cfg_wdata;
				end
				CFG_ACTIVATE_INDEX: begin
					next_activate = cfg_wdata[ACTIVATE_BIT];
				end
				CFG_POWER_CONTROL_INDEX: begin
					next_power_control_config = cfg_wdata;
					next_activate = cfg_wdata[POWER_GAME_BIT];
				end
				default: begin
					next_activate = activate;
				end
			endcase
		end
		next_power_control_config[POWER_GAME_BIT] = next_activate;
		case (cfg_index)
			CFG_BASE_HIGH_INDEX: next_cfg_rdata = next_base_high;
			CFG_BASE_LOW_INDEX: next_cfg_rdata = next_base_low;
			CFG_ACTIVATE_INDEX: next_cfg_rdata = {7'h00, next_activate};
			CFG_POWER_CONTROL_INDEX: next_cfg_rdata = next_power_control_config;
			default: next_cfg_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			base_high <= BASE_HIGH_RESET;
			base_low <= BASE_LOW_RESET;
			activate <= ACTIVATE_RESET;
			power_control_config <= POWER_CONTROL_RESET;
			cfg_rdata <= 8'h00;
		end else begin
			base_high <= next_base_high;
			base_low <= next_base_low;
			activate <= next_activate;
			power_control_config <= next_power_control_config;
			cfg_rdata <= next_cfg_rdata;
		end
	end

	// Address decode
	assign port_base = {base_high, base_low};
	assign address_hit = activate && (io_addr == port_base + PORT_OFFSET);

	// Host cycles and port register
	always_comb begin
		next_write_hit = 1'b0;
		if (io_write) begin
			next_write_hit = write_hit | address_hit;
		end
		next_port_write_cycle = write_prev && !io_write && write_hit;
		next_port_read_cycle = io_read && !read_prev && address_hit;
		next_joystick_port_state = PORT_RESET;
		next_joystick_port_state[STICK1_X_POS] = axis_bits[0];
		next_joystick_port_state[STICK1_Y_POS] = axis_bits[1];
		next_joystick_port_state[STICK2_X_POS] = axis_bits[2];
		next_joystick_port_state[STICK2_Y_POS] = axis_bits[3];
		next_joystick_port_state[STICK1_BUTTON1_POS] = button_sync[0];
		next_joystick_port_state[STICK1_BUTTON2_POS] = button_sync[1];
		next_joystick_port_state[STICK2_BUTTON1_POS] = button_sync[2];
		next_joystick_port_state[STICK2_BUTTON2_POS] = button_sync[3];
		next_io_rdata = 8'h00;
		if (io_read && address_hit) begin
			next_io_rdata = joystick_port_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			write_prev <= 1'b0;
			write_hit <= 1'b0;
			read_prev <= 1'b0;
			port_write_cycle <= 1'b0;
			port_read_cycle <= 1'b0;
			joystick_port_state <= PORT_RESET;
			io_rdata <= 8'h00;
		end else begin
			write_prev <= io_write;
			write_hit <= next_write_hit;
			read_prev <= io_read;
			port_write_cycle <= next_port_write_cycle;
			port_read_cycle <= next_port_read_cycle;
			joystick_port_state <= next_joystick_port_state;
			io_rdata <= next_io_rdata;
		end
	end

	// Four axis timers: stick1 x, stick1 y, stick2 x, stick2 y
	for (genvar i = 0; i < 4; i++) begin : g_axis
		axis_timer_channel #(
			.DISCHARGE_COUNT(DISCHARGE_COUNT)
		) u_axis (
			.clock(clock),
			.resetn(resetn),
			.restart(port_write_cycle),
			.threshold_reached(rc_sync[i]),
			.timer_out(axis_bits[i]),
			.discharge(axis_discharge[i])
		);
	end

	assign stick1_axis_x_discharge = axis_discharge[0];
	assign stick1_axis_y_discharge = axis_discharge[1];
	assign stick2_axis_x_discharge = axis_discharge[2];
	assign stick2_axis_y_discharge = axis_discharge[3];

endmodule

// >>> tb/game_port_checker_assertions.sv
// Port assertions for the dual joystick game port
`timescale 1ns/1ps
module game_port_checker import game_port_pkg::*; #(
	parameter int DISCHARGE_COUNT = DISCHARGE_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic io_read,
	input wire logic io_write,
	input wire logic cfg_write,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic [7:0] io_rdata,
	input wire logic stick1_axis_x_rc_input,
	input wire logic stick1_axis_x_discharge,
	input wire logic port_read_cycle,
	input wire logic port_write_cycle
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	logic base_index;
	assign base_index = cfg_index inside {CFG_BASE_HIGH_INDEX, CFG_BASE_LOW_INDEX};
	AST_WRITE_TRAIL: assert property (port_write_cycle |-> !$past(io_write) && $past(io_write, 2))
		else $error("write pulse without strobe fall");
	AST_WRITE_SINGLE: assert property (port_write_cycle |=> !port_write_cycle)
		else $error("write pulse too long");
	AST_WRITE_RESTART: assert property (port_write_cycle |=> stick1_axis_x_discharge)
		else $error("no discharge after write");
	AST_READ_CAUSE: assert property (port_read_cycle |-> $past(io_read))
		else $error("read pulse without read");
	AST_READ_IDLE: assert property (!$past(io_read) |-> io_rdata == 8'h00)
		else $error("port data without read");
	AST_BASE_BACK: assert property (cfg_write && base_index |=> cfg_rdata == $past(cfg_wdata))
		else $error("base byte readback wrong");
	AST_MIRROR: assert property ((cfg_write && cfg_index == CFG_POWER_CONTROL_INDEX) ##2
		(!cfg_write && cfg_index == CFG_ACTIVATE_INDEX)
		|=> cfg_rdata[ACTIVATE_BIT] == $past(cfg_wdata[POWER_GAME_BIT], 3))
		else $error("activate mirror wrong");
	AST_MIRROR_BACK: assert property ((cfg_write && cfg_index == CFG_ACTIVATE_INDEX) ##2
		(!cfg_write && cfg_index == CFG_POWER_CONTROL_INDEX)
		|=> cfg_rdata[POWER_GAME_BIT] == $past(cfg_wdata[ACTIVATE_BIT], 3))
		else $error("power bit mirror wrong");
	AST_THRESHOLD: assert property (!stick1_axis_x_discharge && stick1_axis_x_rc_input
		|-> ##[1:4] stick1_axis_x_discharge)
		else $error("no discharge at threshold");
	cover property (port_write_cycle);
	cover property (port_read_cycle);
	cover property ($fell(stick1_axis_x_discharge));
endmodule
bind dual_joystick_game_port game_port_checker #(.DISCHARGE_COUNT(DISCHARGE_COUNT)) u_chk (.*);

// >>> tb/rc_pot_model.sv
// Joystick RC networks: comparator trips a set time after release
`timescale 1ns/1ps
module rc_pot_model (
	input wire logic clock,
	input wire logic [3:0] discharge,
	input wire logic [3:0][7:0] charge_cycles,
	output logic [3:0] level
);
	logic [3:0][7:0] count;
	always_ff @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			if (discharge[i]) begin
				count[i] <= 8'h00;
			end else if (count[i] != 8'hff) begin
				count[i] <= count[i] + 8'h01;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			level[i] = !discharge[i] && (count[i] >= charge_cycles[i]);
		end
	end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the dual joystick game port
`timescale 1ns/1ps
module tb import game_port_pkg::*;;
	localparam logic [15:0] BASE = 16'h1234;
	logic clock, resetn, io_read, io_write, cfg_write, port_read_cycle, port_write_cycle, p;
	logic [15:0] io_addr;
	logic [7:0] cfg_index, cfg_wdata, cfg_rdata, io_rdata, seen;
	logic stick1_axis_x_rc_input, stick1_axis_y_rc_input;
	logic stick2_axis_x_rc_input, stick2_axis_y_rc_input;
	logic stick1_button1, stick1_button2, stick2_button1, stick2_button2;
	logic stick1_axis_x_discharge, stick1_axis_y_discharge;
	logic stick2_axis_x_discharge, stick2_axis_y_discharge;
	logic [3:0][7:0] charge;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [11:0] rows [5] = '{12'h110, 12'h220, 12'h440, 12'h880, 12'h000};
	logic [3:0] steps [4] = '{4'he, 4'hc, 4'h8, 4'h0};
	dual_joystick_game_port #(.DISCHARGE_COUNT(4)) u_dut (.*);
	rc_pot_model u_pot (
		.clock(clock),
		.discharge({stick2_axis_y_discharge, stick2_axis_x_discharge,
			stick1_axis_y_discharge, stick1_axis_x_discharge}),
		.charge_cycles(charge),
		.level({stick2_axis_y_rc_input, stick2_axis_x_rc_input,
			stick1_axis_y_rc_input, stick1_axis_x_rc_input})
	);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			conclude();
		end
	end
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] data);
		@(posedge clock);
		cfg_index <= idx;
		cfg_wdata <= data;
		cfg_write <= 1'b1;
		@(posedge clock);
		cfg_write <= 1'b0;
	endtask
	task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
		@(posedge clock);
		cfg_index <= idx;
		@(posedge clock);
		@(negedge clock);
		d = cfg_rdata;
	endtask
	task automatic port_rd(input logic [15:0] addr, output logic [7:0] d, output logic pulse);
		@(posedge clock);
		io_addr <= addr;
		io_read <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		d = io_rdata;
		pulse = port_read_cycle;
		@(posedge clock);
		io_read <= 1'b0;
	endtask
	task automatic port_wr(input logic [15:0] addr, output logic pulse);
		pulse = 1'b0;
		@(posedge clock);
		io_addr <= addr;
		io_write <= 1'b1;
		@(posedge clock);
		io_write <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clock);
			pulse = pulse | port_write_cycle;
		end
	endtask
	initial begin
		{io_read, io_write, cfg_write, resetn} = 4'h0;
		{io_addr, cfg_index, cfg_wdata} = 32'h0000_0000;
		{stick2_button2, stick2_button1, stick1_button2, stick1_button1} = 4'h0;
		charge = {8'h64, 8'h46, 8'h28, 8'h0a};
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		@(negedge clock);
		check("reset port data", 8'h00, io_rdata);
		seen = {4'h0, stick2_axis_y_discharge, stick2_axis_x_discharge,
			stick1_axis_y_discharge, stick1_axis_x_discharge};
		check("reset discharge", 8'h0f, seen);
		cfg_wr(CFG_BASE_HIGH_INDEX, 8'h12);
		cfg_wr(CFG_BASE_LOW_INDEX, 8'h34);
		port_rd(BASE, seen, p);
		check("inactive read", 8'h00, seen);
		port_wr(BASE, p);
		check("inactive write", 8'h00, {7'h00, p});
		cfg_wr(CFG_POWER_CONTROL_INDEX, 8'h04);
		cfg_rd(CFG_ACTIVATE_INDEX, seen);
		check("activate mirror", 8'h01, seen);
		$display("Test config done");
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			{stick2_button2, stick2_button1, stick1_button2, stick1_button1} <= rows[i][11:8];
			repeat (3) @(posedge clock);
			port_rd(BASE, seen, p);
			check("port layout", rows[i][7:0], seen);
			check("read pulse", 8'h01, {7'h00, p});
		end
		port_rd(BASE + 16'h0001, seen, p);
		check("miss read", 8'h00, seen);
		check("miss pulse", 8'h00, {7'h00, p});
		$display("Test buttons done");
		port_wr(BASE, p);
		check("write pulse", 8'h01, {7'h00, p});
		port_rd(BASE, seen, p);
		check("axis restart", 8'h0f, seen);
		for (int k = 0; k < 4; k++) begin
			repeat (30) @(posedge clock);
			port_rd(BASE, seen, p);
			check("axis poll", {4'h0, steps[k]}, seen);
		end
		$display("Test timing done");
		cfg_wr(CFG_ACTIVATE_INDEX, 8'h00);
		cfg_rd(CFG_POWER_CONTROL_INDEX, seen);
		check("power mirror", 8'h00, seen);
		$display("Test mirror done");
		conclude();
	end
endmodule
